// ---- adc_ctrl_pkg.sv ----
// constants shared by the converter control block
// Function
// - repeat 8-bit conversions while enabled
// - normal mode raises irq every conversion
// - compare mode irq only when condition holds
// - resolve bits MSB first using comparator
// - copy final trial value into result
// - reset clears conversion result
// - result keeps its value after mode/channel write
// - mode bit 7 enables continuous conversion
// - time code selects 96..288 clock periods
// - reset clears mode register, stopping conversion
// - channel code selects input 0 to 4
// - compare enable bit 7, polarity bit 6
// - reset clears compare mode register
// - pol 0 fires >=, pol 1 fires below
// - compare mode skips first conversion's irq
// - mode/channel write aborts and restarts conversion
// - mode/channel write beats conversion end, no update/irq
package adc_ctrl_pkg;

    // ********************************************
    // register addresses
    // ********************************************
    localparam logic [15:0] ADDR_MODE      = 16'hFF80;
    localparam logic [15:0] ADDR_CHANNEL   = 16'hFF81;
    localparam logic [15:0] ADDR_CMP_MODE  = 16'hFF82;
    localparam logic [15:0] ADDR_THRESHOLD = 16'hFF83;
    localparam logic [15:0] ADDR_RESULT    = 16'hFF84;

    // ********************************************
    // field positions and reset values
    // ********************************************
    localparam int          MODE_ENABLE_BIT  = 7;
    localparam int          MODE_TIME_HI     = 5;
    localparam int          MODE_TIME_LO     = 3;
    localparam int          CMP_ENABLE_BIT   = 7;
    localparam int          CMP_POLARITY_BIT = 6;
    localparam logic [7:0]  MODE_MASK        = 8'hB8;
    localparam logic [7:0]  CHANNEL_MASK     = 8'h07;
    localparam logic [7:0]  CMP_MASK         = 8'hC0;
    localparam logic [7:0]  REG_RESET        = 8'h00;

    // ********************************************
    // conversion sequencing
    // ********************************************
    localparam int          RESULT_BITS      = 8;
    localparam logic [3:0]  SAMPLE_STEPS     = 4'h4;
    localparam logic [3:0]  STEP_SAMPLE_LAST = 4'h3;
    localparam logic [3:0]  STEP_LAST        = 4'hB;
    localparam int          STEPS_PER_CONV   = 12;
    localparam logic [7:0]  SAR_MSB          = 8'h80;

    // conversion time codes, periods = STEPS_PER_CONV * slot length
    localparam logic [2:0]  TIME_144 = 3'h0;
    localparam logic [2:0]  TIME_120 = 3'h1;
    localparam logic [2:0]  TIME_96  = 3'h2;
    localparam logic [2:0]  TIME_288 = 3'h4;
    localparam logic [2:0]  TIME_240 = 3'h5;
    localparam logic [2:0]  TIME_192 = 3'h6;
    localparam logic [4:0]  SLOT_144 = 5'h0C;
    localparam logic [4:0]  SLOT_120 = 5'h0A;
    localparam logic [4:0]  SLOT_96  = 5'h08;
    localparam logic [4:0]  SLOT_288 = 5'h18;
    localparam logic [4:0]  SLOT_240 = 5'h14;
    localparam logic [4:0]  SLOT_192 = 5'h10;

endpackage : adc_ctrl_pkg

// ---- comparator_sync.sv ----
// three-stage synchroniser with agreement filter for the comparator verdict
`timescale 1ns/1ps
module comparator_sync
(
    input  wire logic sys_clk,
    input  wire logic srst,
    input  wire logic async_in,
    output logic      sync_out
);

    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // ********************************************
    // capture chain
    // ********************************************
    // first stage feeds only the second one
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            s1_reg <= 1'b0;
            s2_reg <= 1'b0;
            s3_reg <= 1'b0;
        end
        else
        begin
            s1_reg <= async_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            sync_out <= 1'b0;
        else if (s2_reg == s3_reg)
            sync_out <= s3_reg;
    end

endmodule : comparator_sync

// ---- sar_adc_power_fail_control.sv ----
// successive-approximation converter sequencer with low-voltage compare
`timescale 1ns/1ps
module sar_adc_power_fail_control
    import adc_ctrl_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [15:0] cpu_addr,
    input  wire logic [7:0]  cpu_wdata,
    input  wire logic        cpu_wr,
    input  wire logic        cpu_rd,
    output logic      [7:0]  cpu_rdata,
    input  wire logic        comparator_in,
    output logic      [7:0]  tap_code,
    output logic      [2:0]  channel_sel,
    output logic             sample_hold,
    output logic             conversion_end_irq
);

    logic [7:0] converter_mode_control;
    logic [7:0] input_channel_select;
    logic [7:0] low_voltage_compare_mode;
    logic [7:0] low_voltage_threshold;
    logic [7:0] conversion_result;
    logic [7:0] approximation_register;
    logic [4:0] slot_reg;
    logic [3:0] step_reg;
    logic       first_done_reg;
    logic       comp_q;
    logic       conversion_enable;
    logic       compare_enable;
    logic       compare_polarity;
    logic       write_hit;
    logic       slot_end;
    logic       conv_done;
    logic       cond_met;
    logic [4:0] slot_len;
    logic [2:0] trial_bit;
    logic [7:0] sar_final;

    // ********************************************
    // helpers
    // ********************************************
    // slot length for a time code; prohibited codes fall back to the 144 setting
    function automatic logic [4:0] slot_of(input logic [2:0] code);
        logic [4:0] len;
        len = SLOT_144;
        unique case (code)
            TIME_120: len = SLOT_120;
            TIME_96:  len = SLOT_96;
            TIME_288: len = SLOT_288;
            TIME_240: len = SLOT_240;
            TIME_192: len = SLOT_192;
            default:  len = SLOT_144;
        endcase
        return len;
    endfunction : slot_of

    // decide one bit and arm the next lower trial bit
    function automatic logic [7:0] trial_update(input logic [7:0] sar,
                                                input logic [2:0] b,
                                                input logic       verdict);
        logic [7:0] v;
        v    = sar;
        v[b] = verdict;
        if (b != 3'h0)
            v[b - 3'h1] = 1'b1;
        return v;
    endfunction : trial_update

    comparator_sync u_comp_sync
    (
        .sys_clk  (sys_clk),
        .srst     (srst),
        .async_in (comparator_in),
        .sync_out (comp_q)
    );

    // ********************************************
    // decode
    // ********************************************
    assign conversion_enable = converter_mode_control[MODE_ENABLE_BIT];
    assign compare_enable    = low_voltage_compare_mode[CMP_ENABLE_BIT];
    assign compare_polarity  = low_voltage_compare_mode[CMP_POLARITY_BIT];
    assign slot_len  = slot_of(converter_mode_control[MODE_TIME_HI:MODE_TIME_LO]);
    assign write_hit = cpu_wr && (cpu_addr == ADDR_MODE || cpu_addr == ADDR_CHANNEL);
    assign slot_end  = (slot_reg == slot_len - 5'h1);
    assign trial_bit = 3'(STEP_LAST - step_reg);
    assign sar_final = trial_update(approximation_register, 3'h0, comp_q);
    // a coinciding mode or channel write wins over the conversion end
    assign conv_done = conversion_enable && !write_hit && slot_end
                       && step_reg == STEP_LAST;
    // unsigned compare of the fresh result against the threshold
    assign cond_met  = compare_polarity ? (sar_final <  low_voltage_threshold)
                                        : (sar_final >= low_voltage_threshold);
    assign tap_code    = approximation_register;
    assign channel_sel = input_channel_select[2:0];
    assign sample_hold = conversion_enable && step_reg < SAMPLE_STEPS;

    // ********************************************
    // register file
    // ********************************************
    // only defined bits are stored, reserved bits read as zero
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            converter_mode_control   <= REG_RESET;
            input_channel_select     <= REG_RESET;
            low_voltage_compare_mode <= REG_RESET;
            low_voltage_threshold    <= REG_RESET;
        end
        else if (cpu_wr)
        begin
            unique case (cpu_addr)
                ADDR_MODE:      converter_mode_control   <= cpu_wdata & MODE_MASK;
                ADDR_CHANNEL:   input_channel_select     <= cpu_wdata & CHANNEL_MASK;
                ADDR_CMP_MODE:  low_voltage_compare_mode <= cpu_wdata & CMP_MASK;
                ADDR_THRESHOLD: low_voltage_threshold    <= cpu_wdata;
                default:        ;
            endcase
        end
    end

    // registered read port; a read sees the result held before any same-cycle load
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            cpu_rdata <= REG_RESET;
        else if (cpu_rd)
        begin
            unique case (cpu_addr)
                ADDR_MODE:      cpu_rdata <= converter_mode_control;
                ADDR_CHANNEL:   cpu_rdata <= input_channel_select;
                ADDR_CMP_MODE:  cpu_rdata <= low_voltage_compare_mode;
                ADDR_THRESHOLD: cpu_rdata <= low_voltage_threshold;
                ADDR_RESULT:    cpu_rdata <= conversion_result;
                default:        cpu_rdata <= REG_RESET;
            endcase
        end
    end

    // ********************************************
    // sequencing
    // ********************************************
    // twelve equal slots: four sampling, eight bit trials
    always_ff @(posedge sys_clk)
    begin
        if (srst || write_hit || !conversion_enable)
        begin
            slot_reg <= 5'h00;
            step_reg <= 4'h0;
        end
        else if (slot_end)
        begin
            slot_reg <= 5'h00;
            step_reg <= (step_reg == STEP_LAST) ? 4'h0 : step_reg + 4'h1;
        end
        else
            slot_reg <= slot_reg + 5'h01;
    end

    // trial value steps from the MSB downward, one bit per slot
    always_ff @(posedge sys_clk)
    begin
        if (srst || write_hit || !conversion_enable)
            approximation_register <= REG_RESET;
        else if (slot_end)
        begin
            if (step_reg == STEP_SAMPLE_LAST)
                approximation_register <= SAR_MSB;
            else if (step_reg == STEP_LAST)
                approximation_register <= REG_RESET;
            else if (step_reg > STEP_SAMPLE_LAST)
                approximation_register <= trial_update(approximation_register,
                                                       trial_bit, comp_q);
        end
    end

    // result load; left untouched by aborted conversions
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            conversion_result <= REG_RESET;
        else if (conv_done)
            conversion_result <= sar_final;
    end

    // first completion after enabling carries no compare interrupt
    always_ff @(posedge sys_clk)
    begin
        if (srst || !conversion_enable)
            first_done_reg <= 1'b0;
        else if (conv_done)
            first_done_reg <= 1'b1;
    end

    // one-cycle interrupt pulse after each qualifying completion
    always_ff @(posedge sys_clk)
    begin
        if (srst)
            conversion_end_irq <= 1'b0;
        else
            conversion_end_irq <= conv_done
                && (!compare_enable || (first_done_reg && cond_met));
    end

    // ********************************************
    // checks
    // ********************************************
    logic [8:0] conv_cnt_reg;

    // cycles since the conversion began, for the timing check
    always_ff @(posedge sys_clk)
    begin
        if (srst || write_hit || !conversion_enable || conv_done)
            conv_cnt_reg <= 9'h000;
        else
            conv_cnt_reg <= conv_cnt_reg + 9'h001;
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (srst);

    a_irq_normal_mode: assert property (
        conv_done && !compare_enable |=> conversion_end_irq)
        else $error("normal mode completion without interrupt");
    a_irq_needs_done: assert property (
        conversion_end_irq |-> $past(conv_done))
        else $error("interrupt without a completed conversion");
    a_write_wins_end: assert property (
        write_hit |=> !conversion_end_irq && $stable(conversion_result))
        else $error("write did not suppress completion");
    a_result_load: assert property (
        conv_done |=> conversion_result == $past(sar_final))
        else $error("result not loaded from trial value");
    a_first_suppressed: assert property (
        conv_done && compare_enable && !first_done_reg |=> !conversion_end_irq)
        else $error("first compare conversion raised interrupt");
    a_polarity_low: assert property (
        conv_done && compare_enable && first_done_reg && !compare_polarity
        && sar_final >= low_voltage_threshold |=> conversion_end_irq)
        else $error("compare at or above threshold missed");
    a_polarity_high: assert property (
        conv_done && compare_enable && first_done_reg && compare_polarity
        && sar_final >= low_voltage_threshold |=> !conversion_end_irq)
        else $error("compare polarity not honoured");
    a_stop_holds: assert property (
        !conversion_enable |=> step_reg == 4'h0 && slot_reg == 5'h00
        && !conversion_end_irq)
        else $error("sequencer ran while disabled");
    a_msb_first: assert property (
        conversion_enable && !write_hit && slot_end && step_reg == STEP_SAMPLE_LAST
        ##1 !write_hit |-> tap_code == SAR_MSB ##1 tap_code == SAR_MSB)
        else $error("first trial is not the MSB");
    a_conv_length: assert property (
        conv_done |-> conv_cnt_reg == 9'(slot_len * STEPS_PER_CONV) - 9'h001)
        else $error("conversion length mismatch");
    a_reset_clears: assert property (
        @(posedge sys_clk) disable iff (1'b0)
        srst |=> conversion_result == REG_RESET && converter_mode_control == REG_RESET
        && input_channel_select == REG_RESET && low_voltage_compare_mode == REG_RESET)
        else $error("reset left a register set");

endmodule : sar_adc_power_fail_control

// ---- analog_front_model.sv ----
// behavioural analog front end: five input levels, sample-hold and tap comparator
`timescale 1ns/1ps
module analog_front_model
(
    input  wire logic        sys_clk,
    input  wire logic [2:0]  channel_sel,
    input  wire logic [7:0]  tap_code,
    input  wire logic        sample_hold,
    input  wire logic [39:0] levels,
    output logic             comparator_in
);
    logic [7:0] held_level = 8'h00;

    // follow the selected input while sampling, freeze it during hold
    always @(posedge sys_clk)
    begin
        if (sample_hold)
        begin
            held_level <= levels[channel_sel * 8 +: 8];
        end
    end

    // verdict lags the tap a little, so the block must not sample it too early
    // settling takes only a few ns, so every time code is long enough here
    always @(held_level or tap_code)
    begin
        comparator_in <= #3 (held_level >= tap_code);
    end
endmodule : analog_front_model

// ---- test_sar_adc_power_fail_control.sv ----
// self-checking bench for the converter control block
`timescale 1ns/1ps
module test_sar_adc_power_fail_control
    import adc_ctrl_pkg::*;
();
    logic        sys_clk;
    logic        srst;
    logic [15:0] cpu_addr;
    logic [7:0]  cpu_wdata;
    logic        cpu_wr;
    logic        cpu_rd;
    logic [7:0]  cpu_rdata;
    logic        comparator_in;
    logic [7:0]  tap_code;
    logic [2:0]  channel_sel;
    logic        sample_hold;
    logic        conversion_end_irq;
    logic [39:0] levels;
    int          bad_count;
    int          num_checks;
    int          n;
    int          p;
    // ********************************************
    // time codes and their conversion lengths
    // ********************************************
    // entry i of each packed list belongs to loop pass i, lowest slice first
    localparam logic [17:0] CODES   = {TIME_192, TIME_240, TIME_288,
                                       TIME_96,  TIME_120, TIME_144};
    localparam logic [53:0] PERIODS = {9'h0C0, 9'h0F0, 9'h120, 9'h060, 9'h078, 9'h090};

    sar_adc_power_fail_control DUT (.sys_clk(sys_clk), .srst(srst), .cpu_addr(cpu_addr),
        .cpu_wdata(cpu_wdata), .cpu_wr(cpu_wr), .cpu_rd(cpu_rd), .cpu_rdata(cpu_rdata),
        .comparator_in(comparator_in), .tap_code(tap_code), .channel_sel(channel_sel),
        .sample_hold(sample_hold), .conversion_end_irq(conversion_end_irq));

    analog_front_model front (.sys_clk(sys_clk), .channel_sel(channel_sel), .tap_code(tap_code),
        .sample_hold(sample_hold), .levels(levels), .comparator_in(comparator_in));

    always #25 sys_clk = ~sys_clk;

    // ********************************************
    // access and compare tasks
    // ********************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp)
        begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic chk_rng(input int got, input int lo, input int hi);
        num_checks++;
        if (got < lo || got > hi)
        begin
            bad_count++;
            $display("Error at %0t: count %0d outside %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng

    // software keeps reserved bits zero in every value written here
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        cpu_addr  <= a;
        cpu_wdata <= d;
        cpu_wr    <= 1'b1;
        @(posedge sys_clk);
        cpu_wr    <= 1'b0;
    endtask : wr

    task automatic rdc(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        cpu_addr <= a;
        cpu_rd   <= 1'b1;
        @(posedge sys_clk);
        cpu_rd   <= 1'b0;
        #1;
        chk(cpu_rdata, exp);
    endtask : rdc

    // bounded wait: n is the number of edges until the pulse was seen
    task automatic wait_irq(input int limit, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge sys_clk);
            #1;
            cnt++;
        end
        while (conversion_end_irq !== 1'b1 && cnt < limit);
    endtask : wait_irq

    task automatic count_irq(input int cycles, output int cnt);
        cnt = 0;
        repeat (cycles)
        begin
            @(posedge sys_clk);
            #1;
            if (conversion_end_irq === 1'b1)
            begin
                cnt++;
            end
        end
    endtask : count_irq

    task automatic final_report();
        if (bad_count == 0 && num_checks > 0)
        begin
            $display("ALL CHECKS OK");
        end
        else
        begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : final_report

    // ********************************************
    // test sequence
    // ********************************************
    initial
    begin
        sys_clk = 1'b0;
        srst = 1'b1;
        cpu_addr = 16'h0000;
        cpu_wdata = 8'h00;
        cpu_wr = 1'b0;
        cpu_rd = 1'b0;
        levels = {8'h37, 8'h80, 8'hFF, 8'h00, 8'h5A};
        bad_count = 0;
        num_checks = 0;
        repeat (20) @(posedge sys_clk);
        srst <= 1'b0;
        rdc(ADDR_MODE, REG_RESET);
        rdc(ADDR_CHANNEL, REG_RESET);
        rdc(ADDR_CMP_MODE, REG_RESET);
        rdc(ADDR_RESULT, REG_RESET);
        rdc(16'hFF90, 8'h00);
        count_irq(300, n);
        chk_rng(n, 0, 0);
        // all six defined time codes, channels cycling through all five inputs
        for (int i = 0; i < 6; i++)
        begin
            wr(ADDR_CHANNEL, 8'(i % 5));
            wr(ADDR_MODE, {2'b10, CODES[i * 3 +: 3], 3'b000});
            rdc(ADDR_MODE, {2'b10, CODES[i * 3 +: 3], 3'b000});
            p = int'(PERIODS[i * 9 +: 9]);
            // the mode readback already used two of the first conversion's cycles
            wait_irq(400, n);
            chk_rng(n, p - 2, p - 2);
            wait_irq(400, n);
            chk_rng(n, p, p);
            rdc(ADDR_RESULT, levels[(i % 5) * 8 +: 8]);
        end
        // abort mid-conversion restarts the full count
        wr(ADDR_CHANNEL, 8'h03);
        wr(ADDR_MODE, 8'h90);
        wait_irq(200, n);
        chk_rng(n, 96, 96);
        repeat (40) @(posedge sys_clk);
        wr(ADDR_CHANNEL, 8'h03);
        wait_irq(200, n);
        chk_rng(n, 94, 99);
        // write landing on the completion edge wins over the result load
        levels[31:24] = 8'hC3;
        repeat (94) @(posedge sys_clk);
        wr(ADDR_MODE, 8'h90);
        #1;
        chk({7'h00, conversion_end_irq}, 8'h00);
        rdc(ADDR_RESULT, 8'h80);
        wait_irq(200, n);
        chk_rng(n, 92, 99);
        rdc(ADDR_RESULT, 8'hC3);
        // compare mode: equal to threshold, first completion suppressed
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_THRESHOLD, 8'hC3);
        wr(ADDR_CMP_MODE, 8'h80);
        rdc(ADDR_CMP_MODE, 8'h80);
        wr(ADDR_MODE, 8'h90);
        count_irq(300, n);
        chk_rng(n, 2, 2);
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_CMP_MODE, 8'hC0);
        wr(ADDR_MODE, 8'h90);
        count_irq(300, n);
        chk_rng(n, 0, 0);
        wr(ADDR_MODE, 8'h10);
        wr(ADDR_THRESHOLD, 8'hC4);
        wr(ADDR_MODE, 8'h90);
        count_irq(300, n);
        chk_rng(n, 2, 2);
        rdc(ADDR_THRESHOLD, 8'hC4);
        // stopped converter stays quiet, result is read-only
        wr(ADDR_MODE, 8'h00);
        count_irq(400, n);
        chk_rng(n, 0, 0);
        wr(ADDR_RESULT, 8'h11);
        rdc(ADDR_RESULT, 8'hC3);
        final_report();
    end

    // hang guard, well past the roughly four thousand three hundred cycles the tests need
    initial
    begin
        repeat (50000) @(posedge sys_clk);
        bad_count++;
        $display("Error at %0t: watchdog expired", $time);
        final_report();
    end
endmodule : test_sar_adc_power_fail_control
